// ---- design/sspc_defines.svh ----
// constants for the sample sync, pin and clock control block
`ifndef SSPC_DEFINES_SVH
`define SSPC_DEFINES_SVH

// ==========================================
// register offsets
`define SSPC_OFS_SAMPLE_PERIOD 8'h12
`define SSPC_OFS_CLK_STATUS 8'h0a
`define SSPC_OFS_CONV_CLK_RATE 8'h4e
`define SSPC_OFS_PIN_SYNC_CFG 8'h4f
`define SSPC_OFS_PIN_DRIVE_CAL 8'h50
`define SSPC_OFS_FREEZE_FCLK 8'h5f

// ==========================================
// reset values
`define SSPC_RST_SAMPLE_PERIOD 16'h0028
`define SSPC_RST_CONV_CLK_RATE 16'h0060
`define SSPC_RST_PIN_SYNC_CFG 16'h2090
`define SSPC_RST_PIN_DRIVE_CAL 16'h0000
`define SSPC_RST_FREEZE_FCLK 16'h0000

// ==========================================
// field positions
`define SSPC_BIT_PIN_B_OE 6
`define SSPC_BIT_PIN_B_IE 5
`define SSPC_SYNC_SEL_HI 3
`define SSPC_SYNC_SEL_LO 2
`define SSPC_BIT_PIN_A_IE 1
`define SSPC_BIT_PIN_B_FUNC 6
`define SSPC_BIT_CAL_START 5
`define SSPC_BIT_FREEZE_B 2
`define SSPC_BIT_FREEZE_A 1
`define SSPC_BIT_FAST_CLK_EN 0
`define SSPC_RATIO_W 12

// ==========================================
// codes
`define SSPC_CONV_RATE_1MHZ 16'h0040
`define SSPC_CONV_RATE_500KHZ 16'h0060
`define SSPC_SYNC_TIMER 2'h0
`define SSPC_SYNC_PIN_A 2'h1
`define SSPC_SYNC_PIN_B 2'h2
`define SSPC_TIMER_MULT 2
`define SSPC_SLOT_COUNT 2

`endif

// ---- design/sspc_pkg.sv ----
// types shared by the sample sync, pin and clock control block
package sspc_pkg;

    // ==========================================
    // register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } sspc_reg_req_t;

    // ==========================================
    // one slot result update
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } sspc_result_t;

    // ==========================================
    // calibration sequencer states
    typedef enum logic [1:0] {
        SSPC_CAL_IDLE,
        SSPC_CAL_ALIGN,
        SSPC_CAL_COUNT,
        SSPC_CAL_DONE
    } sspc_cal_state_t;

endpackage

// ---- design/sspc_top.sv ----
// register bank for sample sync, general pins and clock calibration
// Behaviour
// - rate 0x0040 gives 1 MHz, 0x0060 500 kHz
// - rate matters only in digital integrate mode
// - bit 6 enables pin b output driver
// - bit 5 enables pin b input path
// - bit 1 enables pin a input path
// - sync 00 uses slow clock timer
// - sync 01 triggers on pin a
// - sync 10 triggers on pin b
// - pin b drives low or power-down
// - calibration start begins clock ratio count
// - finished ratio readable in status register
// - second slot freeze blocks its results
// - first slot freeze blocks its results
// - freeze bit 0 enables fast clock
// - timer rate is slow clock over 4*period
`timescale 1ns/10ps
`default_nettype none
`include "sspc_defines.svh"

module sspc_top (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire sspc_pkg::sspc_reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    input wire logic digital_integrate_mode,
    output logic conv_clk_1mhz,
    input wire logic slow_tick,
    input wire logic fast_tick,
    output logic fast_clock_enable,
    output logic cal_busy,
    input wire logic gp_pin_a_i,
    input wire logic gp_pin_b_i,
    output logic gp_pin_b_o,
    output logic gp_pin_b_oe,
    input wire logic afe_power_down,
    output logic sample_start,
    input wire sspc_pkg::sspc_result_t [1:0] slot_result_in,
    output logic [1:0][15:0] slot_result
);
    import sspc_pkg::*;

    // ==========================================
    // register file
    logic [15:0] sample_period_r, sample_period_nxt;
    logic [15:0] conv_rate_r, conv_rate_nxt;
    logic [15:0] pin_sync_r, pin_sync_nxt;
    logic [15:0] drive_cal_r, drive_cal_nxt;
    logic [15:0] freeze_r, freeze_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [`SSPC_RATIO_W-1:0] ratio_r, ratio_nxt;

    // whole-word writes keep reserved bits as written
    always_comb begin
        sample_period_nxt = sample_period_r;
        conv_rate_nxt = conv_rate_r;
        pin_sync_nxt = pin_sync_r;
        drive_cal_nxt = drive_cal_r;
        freeze_nxt = freeze_r;
        if (reg_req.wr) begin
            case (reg_req.addr)
                `SSPC_OFS_SAMPLE_PERIOD: sample_period_nxt = reg_req.wdata;
                `SSPC_OFS_CONV_CLK_RATE: conv_rate_nxt = reg_req.wdata;
                `SSPC_OFS_PIN_SYNC_CFG: pin_sync_nxt = reg_req.wdata;
                `SSPC_OFS_PIN_DRIVE_CAL: drive_cal_nxt = reg_req.wdata;
                `SSPC_OFS_FREEZE_FCLK: freeze_nxt = reg_req.wdata;
                default: begin
                end
            endcase
        end
    end

    // read data comes from a flop, one cycle after the read strobe
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_req.rd) begin
            case (reg_req.addr)
                `SSPC_OFS_SAMPLE_PERIOD: rdata_nxt = sample_period_r;
                `SSPC_OFS_CONV_CLK_RATE: rdata_nxt = conv_rate_r;
                `SSPC_OFS_PIN_SYNC_CFG: rdata_nxt = pin_sync_r;
                `SSPC_OFS_PIN_DRIVE_CAL: rdata_nxt = drive_cal_r;
                `SSPC_OFS_FREEZE_FCLK: rdata_nxt = freeze_r;
                `SSPC_OFS_CLK_STATUS: rdata_nxt = {{(16-`SSPC_RATIO_W){1'b0}}, ratio_r};
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sample_period_r <= `SSPC_RST_SAMPLE_PERIOD;
            conv_rate_r <= `SSPC_RST_CONV_CLK_RATE;
            pin_sync_r <= `SSPC_RST_PIN_SYNC_CFG;
            drive_cal_r <= `SSPC_RST_PIN_DRIVE_CAL;
            freeze_r <= `SSPC_RST_FREEZE_FCLK;
            rdata_r <= 16'h0000;
        end else begin
            sample_period_r <= sample_period_nxt;
            conv_rate_r <= conv_rate_nxt;
            pin_sync_r <= pin_sync_nxt;
            drive_cal_r <= drive_cal_nxt;
            freeze_r <= freeze_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ==========================================
    // converter clock select
    // outside digital integrate mode the converter keeps its slow rate
    always_comb begin
        conv_clk_1mhz = 1'b0;
        if (digital_integrate_mode) begin
            conv_clk_1mhz = (conv_rate_r == `SSPC_CONV_RATE_1MHZ);
        end
    end

    // ==========================================
    // general pins
    logic pin_a_gated, pin_b_gated;
    assign pin_a_gated = gp_pin_a_i & pin_sync_r[`SSPC_BIT_PIN_A_IE];
    assign pin_b_gated = gp_pin_b_i & pin_sync_r[`SSPC_BIT_PIN_B_IE];
    assign gp_pin_b_oe = pin_sync_r[`SSPC_BIT_PIN_B_OE];
    // with bit 6 set the powered-down analog drives the pin, otherwise the pin sits low
    assign gp_pin_b_o = drive_cal_r[`SSPC_BIT_PIN_B_FUNC] & afe_power_down;

    // two-stage synchroniser plus an edge history stage per pin
    logic [1:0] sync1_r, sync1_nxt;
    logic [1:0] sync2_r, sync2_nxt;
    logic [1:0] hist_r, hist_nxt;
    logic [1:0] pin_rise;

    always_comb begin
        sync1_nxt = {pin_b_gated, pin_a_gated};
        sync2_nxt = sync1_r;
        hist_nxt = sync2_r;
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
            hist_r <= 2'h0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            hist_r <= hist_nxt;
        end
    end

    assign pin_rise = sync2_r & ~hist_r;

    // ==========================================
    // sample timer and trigger selection
    logic [1:0] sync_sel;
    logic [17:0] tick_cnt_r, tick_cnt_nxt;
    logic [17:0] period_ticks;
    logic timer_fire;
    logic start_r, start_nxt;

    assign sync_sel = pin_sync_r[`SSPC_SYNC_SEL_HI:`SSPC_SYNC_SEL_LO];
    // four slow ticks per unit of the period register
    assign period_ticks = {sample_period_r, 2'h0} ;

    // a zero period never fires rather than firing every tick
    always_comb begin
        tick_cnt_nxt = tick_cnt_r;
        timer_fire = 1'b0;
        if (sync_sel != `SSPC_SYNC_TIMER || period_ticks == 18'h00000) begin
            tick_cnt_nxt = 18'h00000;
        end else if (slow_tick) begin
            if (tick_cnt_r >= period_ticks - 18'h00001) begin
                tick_cnt_nxt = 18'h00000;
                timer_fire = 1'b1;
            end else begin
                tick_cnt_nxt = tick_cnt_r + 18'h00001;
            end
        end
    end

    // reserved code 11 starts nothing
    always_comb begin
        case (sync_sel)
            `SSPC_SYNC_TIMER: start_nxt = timer_fire;
            `SSPC_SYNC_PIN_A: start_nxt = pin_rise[0];
            `SSPC_SYNC_PIN_B: start_nxt = pin_rise[1];
            default: start_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            tick_cnt_r <= 18'h00000;
            start_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            start_r <= start_nxt;
        end
    end

    assign sample_start = start_r;

    // ==========================================
    // fast clock calibration
    sspc_cal_state_t cal_state_r, cal_state_nxt;
    logic cal_start_d_r, cal_start_d_nxt;
    logic [`SSPC_RATIO_W-1:0] cal_cnt_r, cal_cnt_nxt;
    logic cal_rise;

    assign fast_clock_enable = freeze_r[`SSPC_BIT_FAST_CLK_EN];
    // only a fresh 0 to 1 of the start bit launches a run
    assign cal_rise = drive_cal_r[`SSPC_BIT_CAL_START] & ~cal_start_d_r;

    // count fast ticks across one whole slow period, saturating
    always_comb begin
        cal_state_nxt = cal_state_r;
        cal_cnt_nxt = cal_cnt_r;
        ratio_nxt = ratio_r;
        cal_start_d_nxt = drive_cal_r[`SSPC_BIT_CAL_START];
        case (cal_state_r)
            SSPC_CAL_IDLE: begin
                if (cal_rise) begin
                    cal_state_nxt = SSPC_CAL_ALIGN;
                end
            end
            SSPC_CAL_ALIGN: begin
                cal_cnt_nxt = '0;
                if (slow_tick) begin
                    cal_state_nxt = SSPC_CAL_COUNT;
                end
            end
            SSPC_CAL_COUNT: begin
                if (slow_tick) begin
                    cal_state_nxt = SSPC_CAL_DONE;
                end else if (fast_tick && fast_clock_enable && cal_cnt_r != '1) begin
                    cal_cnt_nxt = cal_cnt_r + 1'b1;
                end
            end
            SSPC_CAL_DONE: begin
                ratio_nxt = cal_cnt_r;
                cal_state_nxt = SSPC_CAL_IDLE;
            end
            default: cal_state_nxt = SSPC_CAL_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cal_state_r <= SSPC_CAL_IDLE;
            cal_cnt_r <= '0;
            ratio_r <= '0;
            cal_start_d_r <= 1'b0;
        end else begin
            cal_state_r <= cal_state_nxt;
            cal_cnt_r <= cal_cnt_nxt;
            ratio_r <= ratio_nxt;
            cal_start_d_r <= cal_start_d_nxt;
        end
    end

    assign cal_busy = (cal_state_r != SSPC_CAL_IDLE);

    // ==========================================
    // per-slot result hold
    // slot 0 is the first slot, slot 1 the second
    logic [1:0] slot_freeze;
    assign slot_freeze = {freeze_r[`SSPC_BIT_FREEZE_B], freeze_r[`SSPC_BIT_FREEZE_A]};

    genvar gi;
    generate
        for (gi = 0; gi < `SSPC_SLOT_COUNT; gi = gi + 1) begin : g_slot
            logic [15:0] res_r, res_nxt;
            always_comb begin
                res_nxt = res_r;
                if (slot_result_in[gi].valid && !slot_freeze[gi]) begin
                    res_nxt = slot_result_in[gi].data;
                end
            end
            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    res_r <= 16'h0000;
                end else begin
                    res_r <= res_nxt;
                end
            end
            assign slot_result[gi] = res_r;
        end
    endgenerate

endmodule

`default_nettype wire

// ---- tb/sspc_top_checker.sv ----
// port checks for the sample sync, pin and clock control block
`timescale 1ns/10ps
`default_nettype none
module sspc_top_checker (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire sspc_pkg::sspc_reg_req_t reg_req,
    input wire logic digital_integrate_mode,
    input wire logic conv_clk_1mhz,
    input wire logic fast_clock_enable,
    input wire logic cal_busy,
    input wire logic gp_pin_b_o,
    input wire logic gp_pin_b_oe,
    input wire logic afe_power_down,
    input wire logic sample_start,
    input wire sspc_pkg::sspc_result_t [1:0] slot_result_in,
    input wire logic [1:0][15:0] slot_result
);
    import sspc_pkg::*;
    // ==========================================
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // mirror of the two slot freeze bits, so a frozen slot that still moves is caught
    logic [1:0] frz_r;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            frz_r <= 2'h0;
        end else if (reg_req.wr && reg_req.addr == 8'h5f) begin
            frz_r <= reg_req.wdata[2:1];
        end
    end
    sequence s_wr(a);
        reg_req.wr && reg_req.addr == a;
    endsequence
    chk_pin_oe_bit: assert property (s_wr(8'h4f) |=> gp_pin_b_oe == $past(reg_req.wdata[6]))
        else $error("pin b enable off its bit");
    chk_fast_clk_bit: assert property (s_wr(8'h5f) |=> fast_clock_enable == $past(reg_req.wdata[0]))
        else $error("fast clock enable off its bit");
    chk_pin_b_func: assert property (gp_pin_b_o |-> afe_power_down)
        else $error("pin b high without power-down");
    chk_rate_mode: assert property (conv_clk_1mhz |-> digital_integrate_mode)
        else $error("fast rate outside integrate mode");
    chk_rate_write: assert property (s_wr(8'h4e) |=>
        conv_clk_1mhz == (digital_integrate_mode && $past(reg_req.wdata) == 16'h0040))
        else $error("converter rate wrong");
    chk_start_pulse: assert property (sample_start |=> !sample_start)
        else $error("sample start longer than one cycle");
    // start bit lands at the write edge, the sequencer leaves idle one edge later, and the rise is sampled on the next edge
    chk_cal_cause: assert property ($rose(cal_busy) |->
        $past(reg_req.wr && reg_req.addr == 8'h50 && reg_req.wdata[5], 2))
        else $error("calibration began without start");
    chk_freeze_a: assert property ($changed(slot_result[0]) |-> $past(slot_result_in[0].valid && !frz_r[0]))
        else $error("slot a result changed while open update missing");
    chk_freeze_b: assert property ($changed(slot_result[1]) |-> $past(slot_result_in[1].valid && !frz_r[1]))
        else $error("slot b result changed while open update missing");
endmodule
bind sspc_top sspc_top_checker i_chk (.core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req),
    .digital_integrate_mode(digital_integrate_mode), .conv_clk_1mhz(conv_clk_1mhz),
    .fast_clock_enable(fast_clock_enable), .cal_busy(cal_busy), .gp_pin_b_o(gp_pin_b_o),
    .gp_pin_b_oe(gp_pin_b_oe), .afe_power_down(afe_power_down), .sample_start(sample_start),
    .slot_result_in(slot_result_in), .slot_result(slot_result));
`default_nettype wire

// ---- tb/sspc_host.sv ----
// host model issuing register writes and reads
`timescale 1ns/10ps
`default_nettype none
module sspc_host (
    input wire logic core_clk,
    output var sspc_pkg::sspc_reg_req_t reg_req
);
    import sspc_pkg::*;
    // ==========================================
    // register cycles, one strobe cycle then idle so strobes never merge
    initial reg_req = '0;
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk) reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk) reg_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk) reg_req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge core_clk) reg_req <= '0;
    endtask
endmodule
`default_nettype wire

// ---- tb/sspc_top_tb_top.sv ----
// self-checking bench for the sample sync, pin and clock control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module sspc_top_tb_top;
    import sspc_pkg::*;
    logic core_clk, reset_n, dim, slow_tick, fast_tick, pa, pb_drv, apd, conv, fce, busy, pbo, pboe, sst, rd_d;
    wire logic pb;
    sspc_reg_req_t reg_req;
    sspc_result_t [1:0] sri;
    logic [1:0][15:0] sr;
    logic [15:0] reg_rdata, lf, v, e0, e1, exp_e;
    logic [15:0] exp_q[$];
    logic [7:0] ofs[7] = '{8'h12, 8'h4e, 8'h4f, 8'h50, 8'h5f, 8'h0a, 8'h33};
    logic [15:0] rst[7] = '{16'h0028, 16'h0060, 16'h2090, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    int n_mismatch = 0, n_tests = 0, n_start = 0, cyc = 0;
    // pin b wire: the block wins while it drives
    assign pb = pboe ? pbo : pb_drv;
    sspc_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .digital_integrate_mode(dim), .conv_clk_1mhz(conv), .slow_tick(slow_tick), .fast_tick(fast_tick),
        .fast_clock_enable(fce), .cal_busy(busy), .gp_pin_a_i(pa), .gp_pin_b_i(pb), .gp_pin_b_o(pbo),
        .gp_pin_b_oe(pboe), .afe_power_down(apd), .sample_start(sst), .slot_result_in(sri), .slot_result(sr));
    sspc_host i_host (.core_clk(core_clk), .reg_req(reg_req));
    // ==========================================
    // clock, watchers, helpers
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        rd_d <= reg_req.rd;
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    always @(negedge core_clk) begin
        if (sst === 1'b1) n_start++;
        if (rd_d === 1'b1) begin
            exp_e = exp_q.pop_front();
            `CHK("reg_rdata", exp_e, reg_rdata)
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        i_host.rd(a);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge core_clk) slow_tick <= 1'b1;
            @(posedge core_clk) slow_tick <= 1'b0;
        end
    endtask
    task automatic try_sync(input logic [15:0] cfg, input logic a, input logic b, input int n, input int e);
        int c0;
        i_host.wr(8'h4f, cfg);
        c0 = n_start;
        pa <= a;
        pb_drv <= b;
        tick(n);
        repeat (6) @(posedge core_clk);
        `CHK("sample_starts", e, n_start - c0)
        pa <= 1'b0;
        pb_drv <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        {reset_n, dim, slow_tick, fast_tick, pa, pb_drv, apd} = '0;
        sri = '0;
        lf = 16'h0036;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        foreach (ofs[i]) rd(ofs[i], rst[i]);
        for (int i = 0; i < 3; i++) begin
            lf = lfsr(lf);
            v = lf & 16'hfff3;
            i_host.wr(8'h4f, v);
            @(negedge core_clk) `CHK("gp_pin_b_oe", v[6], pboe)
            rd(8'h4f, v);
            i_host.wr(8'h50, lf & 16'hffdf);
            rd(8'h50, lf & 16'hffdf);
            i_host.wr(8'h5f, lf);
            @(negedge core_clk) `CHK("fast_clock_enable", lf[0], fce)
            rd(8'h5f, lf);
        end
        i_host.wr(8'h0a, 16'hffff);
        rd(8'h0a, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            i_host.wr(8'h4e, i[0] ? 16'h0040 : 16'h0060);
            dim <= i[1];
            @(negedge core_clk) `CHK("conv_clk_1mhz", i == 3, conv)
        end
        i_host.wr(8'h4f, 16'h20d0);
        for (int i = 0; i < 3; i++) begin
            i_host.wr(8'h50, i < 2 ? 16'h0040 : 16'h0000);
            apd <= i != 0;
            @(negedge core_clk) `CHK("gp_pin_b_o", i == 1, pbo)
        end
        i_host.wr(8'h4f, 16'h2094);
        i_host.wr(8'h12, 16'h0001);
        try_sync(16'h2090, 1'b0, 1'b0, 3, 0);
        try_sync(16'h2090, 1'b0, 1'b0, 1, 1);
        try_sync(16'h2096, 1'b1, 1'b0, 0, 1);
        try_sync(16'h2094, 1'b1, 1'b0, 0, 0);
        try_sync(16'h20b8, 1'b1, 1'b1, 2, 1);
        try_sync(16'h20be, 1'b1, 1'b1, 2, 0);
        i_host.wr(8'h5f, 16'h0001);
        i_host.wr(8'h50, 16'h0000);
        i_host.wr(8'h50, 16'h0020);
        // the start bit lands at the write edge, the sequencer leaves idle one edge later
        @(posedge core_clk);
        @(negedge core_clk) `CHK("cal_busy", 1'b1, busy)
        tick(1);
        repeat (5) begin
            @(posedge core_clk) fast_tick <= 1'b1;
            @(posedge core_clk) fast_tick <= 1'b0;
        end
        tick(1);
        repeat (10) if (busy === 1'b1) @(posedge core_clk);
        rd(8'h0a, 16'h0005);
        i_host.wr(8'h50, 16'h0020);
        @(posedge core_clk);
        @(negedge core_clk) `CHK("cal_busy", 1'b0, busy)
        for (int f = 0; f < 3; f++) begin
            lf = lfsr(lf);
            i_host.wr(8'h5f, 16'(f * 2));
            sri <= {1'b1, ~lf, 1'b1, lf};
            @(posedge core_clk) sri <= '0;
            if (f != 1) e0 = lf;
            if (f != 2) e1 = ~lf;
            @(posedge core_clk);
            @(negedge core_clk) `CHK("slot_result0", e0, sr[0])
            `CHK("slot_result1", e1, sr[1])
        end
        repeat (3) @(posedge core_clk);
        report_and_stop();
    end
endmodule
`default_nettype wire
